// ---- core/pcsd_clock_ctrl.sv ----
// pci clock select and divide block with apb registers
//
// How it works
// - host mode uses host input clock
// - host clock feeds divide by two
// - sync output undivided or halved by strap
// - each pci output divided per select bit
// - sync feedback input realigns internal clocks
// - agent mode uses incoming pci clock
// - local bus clock is half/quarter/eighth
// - interface clock one or two times system
// - memory data two beats per clock
// - pll factor decoded from four-bit code
//
// Chosen here: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
module pcsd_clock_ctrl
  import pcsd_pkg::*;
#(
  parameter int NUM_PCI_OUT = PCSD_NUM_PCI_OUT
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [PCSD_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // pins and straps
  input wire logic host_input_clock,
  input wire logic pci_clock_in,
  input wire logic sync_feedback_in,
  input wire logic host_mode_strap,
  input wire logic input_divide_config,
  // generated clocks
  output logic pci_sync_out,
  output logic [NUM_PCI_OUT-1:0] pci_clock_out,
  output logic local_bus_clock,
  output logic memory_bus_clock,
  output logic memory_data_beat,
  // clock settings to other modules
  output logic [4:0] system_pll_factor,
  output logic [3:0] core_pll_setting,
  output logic [1:0] security_clock_mode,
  output logic [1:0] dual_role_usb_clock_mode,
  output logic [1:0] multiport_usb_clock_mode
);

  localparam int SY_HCLK = 0;
  localparam int SY_PCLK = 1;
  localparam int SY_SYNC = 2;
  localparam int SY_HOST = 3;
  localparam int SY_DIV = 4;

  logic [4:0] pin_meta;
  logic [4:0] pin_sync;
  logic [1:0] cap_cnt;
  logic cfg_taken;
  logic host_mode;
  logic div_cfg;
  logic prim_prev;
  logic prim_now;
  logic prim_rise;
  logic half_clk;
  logic sync_prev;
  logic sync_rise;
  logic sync_seen;
  logic csb_phase;
  logic csb_tick;
  logic lbiu_tick;
  logic mem_prev;
  logic [NUM_PCI_OUT-1:0] output_clock_control_reg;
  logic [1:0] local_bus_divider;
  logic [3:0] pll_code;
  logic lbiu_2x;
  logic [2:0] lbus_half;
  logic lbus_clk;
  logic mem_clk;
  pcsd_apb_state_t apb_state;
  logic [31:0] next_rdata;
  logic next_err;
  logic wr_en;

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_meta <= 5'h00;
      pin_sync <= 5'h00;
    end else begin
      pin_meta <= {input_divide_config, host_mode_strap, sync_feedback_in,
                   pci_clock_in, host_input_clock};
      pin_sync <= pin_meta;
    end
  end

  // ---------------------------------------------------------------
  // strap capture after reset release
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap_cnt <= 2'h0;
      cfg_taken <= 1'b0;
      host_mode <= 1'b0;
      div_cfg <= 1'b0;
    end else if (!cfg_taken) begin
      if (cap_cnt == PCSD_CAPTURE_DELAY) begin
        cfg_taken <= 1'b1;
        host_mode <= pin_sync[SY_HOST];
        div_cfg <= pin_sync[SY_DIV];
      end else begin
        cap_cnt <= cap_cnt + 2'h1;
      end
    end
  end

  // ---------------------------------------------------------------
  // primary clock select and divide by two
  // ---------------------------------------------------------------
  assign prim_now = host_mode ? pin_sync[SY_HCLK] : pin_sync[SY_PCLK];
  assign prim_rise = prim_now & ~prim_prev;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prim_prev <= 1'b0;
      half_clk <= 1'b0;
    end else begin
      prim_prev <= prim_now;
      if (cfg_taken && prim_rise) begin
        half_clk <= ~half_clk;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pci_sync_out <= 1'b0;
    end else if (cfg_taken) begin
      pci_sync_out <= div_cfg ? half_clk : prim_now;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < NUM_PCI_OUT; gi++) begin : g_pci_out
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          pci_clock_out[gi] <= 1'b0;
        end else if (cfg_taken) begin
          pci_clock_out[gi] <= output_clock_control_reg[gi] ? half_clk : prim_now;
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // internal timebase aligned to sync feedback
  // ---------------------------------------------------------------
  assign sync_rise = pin_sync[SY_SYNC] & ~sync_prev;
  assign csb_tick = csb_phase;
  assign lbiu_tick = lbiu_2x ? 1'b1 : csb_tick;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_prev <= 1'b0;
      sync_seen <= 1'b0;
      csb_phase <= 1'b0;
    end else begin
      sync_prev <= pin_sync[SY_SYNC];
      if (sync_rise) begin
        sync_seen <= 1'b1;
        csb_phase <= 1'b0;
      end else begin
        csb_phase <= ~csb_phase;
      end
    end
  end

  always_comb begin
    case (local_bus_divider)
      PCSD_LDIV_2: lbus_half = PCSD_HALF_2;
      PCSD_LDIV_4: lbus_half = PCSD_HALF_4;
      PCSD_LDIV_8: lbus_half = PCSD_HALF_8;
      default: lbus_half = PCSD_HALF_8;
    endcase
  end

  pcsd_divider u_lbus_div (
    .pclk(pclk),
    .presetn(presetn),
    .clear(sync_rise),
    .tick(lbiu_tick),
    .half_count(lbus_half),
    .clk_out(lbus_clk)
  );

  pcsd_divider u_mem_div (
    .pclk(pclk),
    .presetn(presetn),
    .clear(sync_rise),
    .tick(csb_tick),
    .half_count(PCSD_HALF_2),
    .clk_out(mem_clk)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      local_bus_clock <= 1'b0;
      memory_bus_clock <= 1'b0;
      mem_prev <= 1'b0;
      memory_data_beat <= 1'b0;
      system_pll_factor <= 5'h00;
    end else begin
      local_bus_clock <= lbus_clk;
      memory_bus_clock <= mem_clk;
      mem_prev <= mem_clk;
      memory_data_beat <= mem_clk ^ mem_prev;
      system_pll_factor <= pcsd_pll_factor(pll_code);
    end
  end

  // ---------------------------------------------------------------
  // apb registers
  // ---------------------------------------------------------------
  assign wr_en = psel && penable && pready && pwrite && !pslverr;

  always_comb begin
    next_rdata = 32'h0000_0000;
    next_err = 1'b0;
    case (paddr)
      PCSD_OUT_CTRL_ADDR: next_rdata[NUM_PCI_OUT-1:0] = output_clock_control_reg;
      PCSD_LOCAL_CTRL_ADDR: next_rdata[1:0] = local_bus_divider;
      PCSD_RESET_WORD_ADDR: begin
        next_rdata[PCSD_PLL_CODE_LSB +: 4] = pll_code;
        next_rdata[PCSD_IFACE_MODE_BIT] = lbiu_2x;
        next_rdata[PCSD_CORE_LSB +: 4] = core_pll_setting;
      end
      PCSD_SYS_CTRL_ADDR: begin
        next_rdata[PCSD_SEC_LSB +: 2] = security_clock_mode;
        next_rdata[PCSD_DRU_LSB +: 2] = dual_role_usb_clock_mode;
        next_rdata[PCSD_MPU_LSB +: 2] = multiport_usb_clock_mode;
      end
      PCSD_STAT_ADDR: begin
        next_rdata[0] = host_mode;
        next_rdata[1] = div_cfg;
        next_rdata[2] = sync_seen;
        next_rdata[3] = (pll_code == PCSD_PLL_CODE_RSVD);
        next_rdata[8:4] = system_pll_factor;
        next_rdata[9] = cfg_taken;
        next_err = pwrite;
      end
      default: next_err = 1'b1;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      apb_state <= PCSD_APB_IDLE;
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      case (apb_state)
        PCSD_APB_IDLE: begin
          if (psel && !penable) begin
            apb_state <= PCSD_APB_ANSWER;
            pready <= 1'b1;
            pslverr <= next_err;
            prdata <= pwrite ? 32'h0000_0000 : next_rdata;
          end
        end
        PCSD_APB_ANSWER: begin
          apb_state <= PCSD_APB_IDLE;
          pready <= 1'b0;
          pslverr <= 1'b0;
        end
        default: apb_state <= PCSD_APB_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      output_clock_control_reg <= '0;
      local_bus_divider <= PCSD_LOCAL_DIV_RESET;
      pll_code <= PCSD_PLL_CODE_RESET;
      lbiu_2x <= PCSD_IFACE_MODE_RESET;
      core_pll_setting <= PCSD_CORE_RESET;
      security_clock_mode <= PCSD_MODE_RESET;
      dual_role_usb_clock_mode <= PCSD_MODE_RESET;
      multiport_usb_clock_mode <= PCSD_MODE_RESET;
    end else if (wr_en) begin
      case (paddr)
        PCSD_OUT_CTRL_ADDR: output_clock_control_reg <= pwdata[NUM_PCI_OUT-1:0];
        PCSD_LOCAL_CTRL_ADDR: local_bus_divider <= pwdata[1:0];
        PCSD_RESET_WORD_ADDR: begin
          pll_code <= pwdata[PCSD_PLL_CODE_LSB +: 4];
          lbiu_2x <= pwdata[PCSD_IFACE_MODE_BIT];
          core_pll_setting <= pwdata[PCSD_CORE_LSB +: 4];
        end
        PCSD_SYS_CTRL_ADDR: begin
          security_clock_mode <= pwdata[PCSD_SEC_LSB +: 2];
          dual_role_usb_clock_mode <= pwdata[PCSD_DRU_LSB +: 2];
          multiport_usb_clock_mode <= pwdata[PCSD_MPU_LSB +: 2];
        end
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_host_edge;
    cfg_taken && host_mode && pin_sync[SY_HCLK] && !prim_prev;
  endsequence

  sequence s_agent_edge;
    cfg_taken && !host_mode && pin_sync[SY_PCLK] && !prim_prev;
  endsequence

  sequence s_fast_lbus;
    (lbiu_2x && local_bus_divider == PCSD_LDIV_2 && !sync_rise) [*3];
  endsequence

  a_host_clock_halved: assert property (s_host_edge |=> half_clk != $past(half_clk))
    else $error("host clock edge did not toggle half clock");
  a_agent_clock_halved: assert property (s_agent_edge |=> half_clk != $past(half_clk))
    else $error("pci clock edge did not toggle half clock in agent mode");
  a_sync_out_select: assert property (cfg_taken && !div_cfg |=> pci_sync_out == $past(prim_now))
    else $error("sync output not the undivided clock");
  a_pci_out_select: assert property (cfg_taken && output_clock_control_reg[0]
    |=> pci_clock_out[0] == $past(half_clk))
    else $error("pci output not the halved clock");
  a_sync_realign: assert property (sync_rise |=> !csb_phase ##1 csb_phase)
    else $error("timebase not realigned to sync feedback");
  a_lbus_fast_div: assert property (s_fast_lbus |=> local_bus_clock != $past(local_bus_clock))
    else $error("local bus clock not half of interface clock");
  a_lbiu_one_x: assert property (!lbiu_2x && !sync_rise && csb_phase |=> lbiu_tick == lbiu_2x)
    else $error("interface tick ran faster than system tick");
  a_mem_two_beats: assert property ($changed(memory_bus_clock) |-> memory_data_beat)
    else $error("memory clock edge without data beat");
  a_pll_x16: assert property (pll_code == PCSD_PLL_CODE_X16 |=> system_pll_factor == PCSD_FACTOR_16)
    else $error("code zero not decoded as sixteen");
  a_strap_hold: assert property (cfg_taken |=> $stable(host_mode) && $stable(div_cfg))
    else $error("straps changed after capture");

endmodule // pcsd_clock_ctrl

// ---- core/pcsd_divider.sv ----
// tick driven clock divider with phase clear
`timescale 1ns/1ps
module pcsd_divider
  import pcsd_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // control
  input wire logic clear,
  input wire logic tick,
  input wire logic [2:0] half_count,
  // divided clock
  output logic clk_out
);

  logic [2:0] cnt;

  // ---------------------------------------------------------------
  // count ticks, toggle every half period
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 3'h0;
      clk_out <= 1'b0;
    end else if (clear) begin
      cnt <= 3'h0;
      clk_out <= 1'b0;
    end else if (tick) begin
      if (cnt >= half_count - 3'h1) begin
        cnt <= 3'h0;
        clk_out <= ~clk_out;
      end else begin
        cnt <= cnt + 3'h1;
      end
    end
  end

endmodule // pcsd_divider

// ---- dv/pci_clock_select_and_divide_bench.sv ----
// self-checking bench for the clock select and divide block
`timescale 1ns/1ps
module pci_clock_select_and_divide_bench
  import pcsd_pkg::*;
;
  logic pclk = 1'b0;
  logic presetn, psel, penable, pwrite, host_mode_strap, input_divide_config, run;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r, e_v, m_v;
  logic pready, pslverr, host_input_clock, pci_clock_in, sync_feedback_in;
  logic pci_sync_out, local_bus_clock, memory_bus_clock, memory_data_beat, s_v;
  logic [4:0] pci_clock_out, system_pll_factor;
  logic [3:0] core_pll_setting;
  logic [1:0] security_clock_mode, dual_role_usb_clock_mode, multiport_usb_clock_mode;
  wire [7:0] probe = {memory_bus_clock, local_bus_clock, pci_clock_out, pci_sync_out};
  int err_count = 0;
  int samples_checked = 0;
  int p, b;
  integer seed = 32'h1eaef7b2;
  logic [31:0] q_e[$], q_m[$];
  logic q_s[$];

  always #12.5 pclk = ~pclk;

  pcsd_clock_ctrl pcsd_clock_ctrl_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .host_input_clock(host_input_clock),
    .pci_clock_in(pci_clock_in), .sync_feedback_in(sync_feedback_in),
    .host_mode_strap(host_mode_strap), .input_divide_config(input_divide_config),
    .pci_sync_out(pci_sync_out), .pci_clock_out(pci_clock_out),
    .local_bus_clock(local_bus_clock), .memory_bus_clock(memory_bus_clock),
    .memory_data_beat(memory_data_beat), .system_pll_factor(system_pll_factor),
    .core_pll_setting(core_pll_setting), .security_clock_mode(security_clock_mode),
    .dual_role_usb_clock_mode(dual_role_usb_clock_mode),
    .multiport_usb_clock_mode(multiport_usb_clock_mode));

  pcsd_board pcsd_board_i (.pclk(pclk), .host_mode(host_mode_strap), .run(run),
    .pci_sync_out(pci_sync_out), .host_input_clock(host_input_clock),
    .pci_clock_in(pci_clock_in), .sync_feedback_in(sync_feedback_in));

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [31:0] e, input logic [31:0] m, input logic s);
    int n;
    n = 0;
    q_e.push_back(e);
    q_m.push_back(m);
    q_s.push_back(s);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(negedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) chk("pready", 0, 1);
    @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic period(input int k, output int pp, output int bb);
    int n;
    logic l;
    n = 0;
    pp = 0;
    bb = 0;
    for (int e = 0; e < 2; e++) begin
      do begin
        l = probe[k];
        @(negedge pclk);
        n++;
        if (e == 1) pp++;
        if (e == 1 && memory_data_beat === 1'b1) bb++;
      end while (!(l === 1'b0 && probe[k] === 1'b1) && n < 400);
    end
  endtask

  task automatic do_reset(input logic h, input logic dv);
    @(posedge pclk);
    presetn <= 1'b0;
    host_mode_strap <= h;
    input_divide_config <= dv;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    repeat (6) @(posedge pclk);
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // response monitor
  // ---------------------------------------------------------------
  always @(negedge pclk) begin
    if (pready === 1'b1) begin
      if (q_e.size() == 0) begin
        chk("unexpected answer", 0, 1);
      end else begin
        e_v = q_e.pop_front();
        m_v = q_m.pop_front();
        s_v = q_s.pop_front();
        chk("read data", prdata & m_v, e_v);
        chk("slave error", {31'h0, pslverr}, {31'h0, s_v});
      end
    end
  end

  // ---------------------------------------------------------------
  // main sequence and watchdog
  // ---------------------------------------------------------------
  initial begin
    #1500000;
    err_count++;
    wrap_up;
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    run = 1'b1;
    host_mode_strap = 1'b1;
    input_divide_config = 1'b1;
    do_reset(1'b1, 1'b1);
    apb(0, PCSD_OUT_CTRL_ADDR, 0, 32'h0, 32'h1F, 0);
    apb(0, PCSD_LOCAL_CTRL_ADDR, 0, 32'h0, 32'h3, 0);
    apb(0, PCSD_RESET_WORD_ADDR, 0, 32'h204, 32'hF1F, 0);
    apb(0, PCSD_SYS_CTRL_ADDR, 0, 32'h15, 32'h3F, 0);
    apb(0, PCSD_STAT_ADDR, 0, 32'h243, 32'h3F3, 0);
    apb(0, 12'h020, 0, 32'h0, 32'hFFFFFFFF, 1);
    apb(1, PCSD_STAT_ADDR, 32'hFFFF, 32'h0, 32'h0, 1);
    apb(0, PCSD_STAT_ADDR, 0, 32'h243, 32'h3F3, 0);
    $display("test registers done");
    for (int c = 0; c < 7; c++) begin
      apb(1, PCSD_RESET_WORD_ADDR, {20'h0, 4'h9, 4'h0, 4'(c)}, 0, 0, 0);
      repeat (3) @(posedge pclk);
      chk("pll factor", {27'h0, system_pll_factor}, c == 0 ? 16 : c == 1 ? 0 : c);
      chk("core pll", {28'h0, core_pll_setting}, 32'h9);
    end
    apb(1, PCSD_SYS_CTRL_ADDR, 32'h26, 0, 0, 0);
    @(negedge pclk);
    chk("modes", {26'h0, multiport_usb_clock_mode, dual_role_usb_clock_mode,
                  security_clock_mode}, 32'h26);
    $display("test pll and modes done");
    period(0, p, b);
    period(0, p, b);
    chk("sync halved", p, 12);
    r = $random(seed) & 32'h1F;
    apb(1, PCSD_OUT_CTRL_ADDR, r, 0, 0, 0);
    for (int i = 0; i < 5; i++) begin
      period(i + 1, p, b);
      period(i + 1, p, b);
      chk("pci out", p, r[i] ? 12 : 6);
    end
    @(posedge pclk);
    input_divide_config <= 1'b0;
    period(0, p, b);
    period(0, p, b);
    chk("sync held", p, 12);
    $display("test host clocks done");
    @(posedge pclk);
    run <= 1'b0;
    repeat (20) @(posedge pclk);
    for (int lb = 0; lb < 2; lb++) begin
      for (int d = 0; d < 4; d++) begin
        apb(1, PCSD_RESET_WORD_ADDR, {20'h0, 4'h2, 3'h0, 1'(lb), 4'h4}, 0, 0, 0);
        apb(1, PCSD_LOCAL_CTRL_ADDR, d, 0, 0, 0);
        period(6, p, b);
        period(6, p, b);
        chk("local clock", p, (2 << (d > 2 ? 2 : d)) * (lb == 1 ? 1 : 2));
        period(7, p, b);
        period(7, p, b);
        chk("beats", b, 2);
      end
    end
    $display("test local and memory done");
    @(posedge pclk);
    run <= 1'b1;
    do_reset(1'b0, 1'b0);
    period(0, p, b);
    period(0, p, b);
    chk("agent sync", p, 6);
    period(1, p, b);
    period(1, p, b);
    chk("agent out", p, 6);
    apb(0, PCSD_STAT_ADDR, 0, 32'h240, 32'h3F3, 0);
    $display("test agent done");
    repeat (4) @(posedge pclk);
    wrap_up;
  end
endmodule // pci_clock_select_and_divide_bench

// ---- dv/pcsd_board.sv ----
// board clock network model: oscillator, grounded unused clock, sync loopback
`timescale 1ns/1ps
module pcsd_board #(
  parameter int HALF = 3,
  parameter int DLY = 2
) (
  // clock
  input wire logic pclk,
  // board straps and oscillator control
  input wire logic host_mode,
  input wire logic run,
  // pins
  input wire logic pci_sync_out,
  output logic host_input_clock,
  output logic pci_clock_in,
  output logic sync_feedback_in
);
  int cnt = 0;
  logic osc = 1'b0;
  logic [DLY-1:0] dly = '0;
  // ---------------------------------------------------------------
  // oscillator, stands still when stopped
  // ---------------------------------------------------------------
  always @(posedge pclk) begin
    if (run) begin
      cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
      if (cnt == HALF - 1) osc <= ~osc;
    end
    dly <= {dly[DLY-2:0], pci_sync_out};
  end
  assign host_input_clock = host_mode & osc;
  assign pci_clock_in = ~host_mode & osc;
  assign sync_feedback_in = dly[DLY-1];
endmodule // pcsd_board

// ---- shared/pcsd_pkg.sv ----
// constants and helpers shared by the pci clock select and divide block
package pcsd_pkg;

  // ---------------------------------------------------------------
  // bus and register map
  // ---------------------------------------------------------------
  localparam int PCSD_ADDR_W = 12;
  localparam int PCSD_NUM_PCI_OUT = 5;
  localparam logic [11:0] PCSD_OUT_CTRL_ADDR = 12'h000;
  localparam logic [11:0] PCSD_LOCAL_CTRL_ADDR = 12'h004;
  localparam logic [11:0] PCSD_RESET_WORD_ADDR = 12'h008;
  localparam logic [11:0] PCSD_SYS_CTRL_ADDR = 12'h00C;
  localparam logic [11:0] PCSD_STAT_ADDR = 12'h010;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int PCSD_PLL_CODE_LSB = 0;
  localparam int PCSD_IFACE_MODE_BIT = 4;
  localparam int PCSD_CORE_LSB = 8;
  localparam int PCSD_SEC_LSB = 0;
  localparam int PCSD_DRU_LSB = 2;
  localparam int PCSD_MPU_LSB = 4;

  // ---------------------------------------------------------------
  // values after reset
  // ---------------------------------------------------------------
  localparam logic [1:0] PCSD_LOCAL_DIV_RESET = 2'h0;
  localparam logic [3:0] PCSD_PLL_CODE_RESET = 4'h4;
  localparam logic PCSD_IFACE_MODE_RESET = 1'b0;
  localparam logic [3:0] PCSD_CORE_RESET = 4'h2;
  localparam logic [1:0] PCSD_MODE_RESET = 2'h1;

  // ---------------------------------------------------------------
  // encodings and counts
  // ---------------------------------------------------------------
  localparam logic [1:0] PCSD_LDIV_2 = 2'h0;
  localparam logic [1:0] PCSD_LDIV_4 = 2'h1;
  localparam logic [1:0] PCSD_LDIV_8 = 2'h2;
  localparam logic [2:0] PCSD_HALF_2 = 3'h1;
  localparam logic [2:0] PCSD_HALF_4 = 3'h2;
  localparam logic [2:0] PCSD_HALF_8 = 3'h4;
  localparam logic [3:0] PCSD_PLL_CODE_X16 = 4'h0;
  localparam logic [3:0] PCSD_PLL_CODE_RSVD = 4'h1;
  localparam logic [4:0] PCSD_FACTOR_16 = 5'h10;
  localparam logic [1:0] PCSD_CAPTURE_DELAY = 2'h2;

  typedef enum logic [0:0] {
    PCSD_APB_IDLE = 1'b0,
    PCSD_APB_ANSWER = 1'b1
  } pcsd_apb_state_t;

  // multiplication factor from the 4-bit code; zero marks the reserved code
  function automatic logic [4:0] pcsd_pll_factor(input logic [3:0] code);
    logic [4:0] f;
    f = {1'b0, code};
    if (code == PCSD_PLL_CODE_X16) begin
      f = PCSD_FACTOR_16;
    end else if (code == PCSD_PLL_CODE_RSVD) begin
      f = 5'h00;
    end
    return f;
  endfunction

endpackage
